// file: verilog/ctep_pkg.sv
// Purpose: Shared constants and types for the CAN transceiver and expansion port block
// Assumes: AXI4-Lite, 32-bit data, two CAN channels
// Notes:   Offsets are byte addresses
package ctep_pkg;
	localparam int          NUM_CH          = 2;
	localparam int          ADDR_W          = 6;
	// Register offsets
	localparam logic [5:0]  OFS_CAN0_OUT    = 6'h00;
	localparam logic [5:0]  OFS_CAN1_OUT    = 6'h04;
	localparam logic [5:0]  OFS_CAN0_IN     = 6'h08;
	localparam logic [5:0]  OFS_CAN1_IN     = 6'h0C;
	localparam logic [5:0]  OFS_EXP_DIR     = 6'h10;
	localparam logic [5:0]  OFS_EXP_OUT     = 6'h14;
	localparam logic [5:0]  OFS_EXP_IN      = 6'h18;
	localparam logic [5:0]  OFS_CTRL        = 6'h1C;
	// CAN port field positions
	localparam int          BIT_TRM         = 4;
	localparam int          BIT_ERR         = 5;
	localparam int          BIT_STB         = 6;
	localparam int          BIT_EN          = 7;
	localparam logic [7:0]  CAN_OUT_MASK    = 8'hC0;
	localparam logic [7:0]  CAN_IN_MASK     = 8'h30;
	// Levels applied when a channel is initialised: standby released, enable set
	localparam logic [7:0]  CAN_RUN_VALUE   = 8'h80;
	// Control register fields
	localparam int          BIT_INIT0       = 0;
	localparam int          BIT_SAVE        = 8;
	// Reset values
	localparam logic [7:0]  RST_CAN_OUT     = 8'h00;
	localparam logic [7:0]  RST_EXP_DIR     = 8'h00;
	localparam logic [7:0]  RST_EXP_OUT     = 8'h00;
	localparam logic [1:0]  RESP_OKAY       = 2'b00;
	localparam logic [1:0]  RESP_SLVERR     = 2'b10;

	// Saved image kept in non-volatile storage
	typedef struct packed {
		logic [7:0] can1_out;
		logic [7:0] can0_out;
		logic [7:0] exp_dir;
		logic [7:0] exp_out;
	} ctep_image_t;

	typedef struct packed {
		logic stb;
		logic en;
	} ctep_xcvr_t;
endpackage : ctep_pkg

// file: verilog/ctep_sync2.sv
// Purpose: Two-flop synchroniser for a bus of pin inputs
// Assumes: Inputs are asynchronous to clk
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module ctep_sync2 #(
	parameter int W = 1
) (
	input  wire logic         clk,
	input  wire logic         rst,
	input  wire logic [W-1:0] d,
	output logic      [W-1:0] q
);
	logic [W-1:0] meta_ff;
	logic [W-1:0] q_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			meta_ff <= '0;
			q_ff    <= '0;
		end else begin
			meta_ff <= d;
			q_ff    <= meta_ff;
		end
	end

	assign q = q_ff;
endmodule : ctep_sync2
`default_nettype wire

// file: verilog/ctep_can_chan.sv
// Purpose: Output latch of one CAN transceiver control port
// Assumes: Writes already decoded for this channel
// Notes:   Undefined bit positions are never stored
`timescale 1ns/1ps
`default_nettype none
module ctep_can_chan (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       restore,
	input  wire logic [7:0] restore_val,
	input  wire logic       init,
	input  wire logic       wr,
	input  wire logic [7:0] wdata,
	output logic      [7:0] last_out,
	output logic            stb_out,
	output logic            en_out
);
	logic [7:0] out_ff;
	logic [7:0] nxt_out;

	// A host write issued together with init takes priority, being the newer intent
	assign nxt_out = wr      ? (wdata & ctep_pkg::CAN_OUT_MASK) :
	                 init    ? ctep_pkg::CAN_RUN_VALUE :
	                 restore ? (restore_val & ctep_pkg::CAN_OUT_MASK) :
	                 out_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			out_ff <= ctep_pkg::RST_CAN_OUT;
		end else begin
			out_ff <= nxt_out;
		end
	end

	assign last_out = out_ff;
	assign stb_out  = out_ff[ctep_pkg::BIT_STB];
	assign en_out   = out_ff[ctep_pkg::BIT_EN];
endmodule : ctep_can_chan
`default_nettype wire

// file: verilog/ctep_top.sv
// Purpose: CAN transceiver control ports and 8-bit expansion port behind AXI4-Lite
// Assumes: One clock, async active-high reset, pins sampled through two flops
// Notes:   Non-volatile image is an external store loaded at power-on
// Summary of operation
// - Input bit 0x20 of a CAN port reports the transceiver error line.
// - Output bit 0x40 of a CAN port drives the transceiver standby pin.
// - Output bit 0x80 of a CAN port drives the transceiver enable pin.
// - Initialising a CAN channel sets standby and enable for normal operation by itself.
// - The last written CAN port output value is saved and reapplied after power-on; the code saves it only when control bit 8 requests a save.
// - Each CAN channel has its own port, chosen by channel index, and reads return its inputs.
// - Each expansion pin has a direction bit, 0 for input and 1 for driven output.
// - After power-up all eight expansion pins are inputs.
// - The last expansion direction setting is saved and reapplied after power-on; the code saves it only when control bit 8 requests a save.
// - A written expansion value appears only on pins set as outputs.
// - Reading the expansion port returns the level of all eight pins.
`timescale 1ns/1ps
`default_nettype none
module ctep_top (
	input  wire logic                      clk,
	input  wire logic                      rst,
	// AXI4-Lite slave
	input  wire logic [5:0]                s_axi_awaddr,
	input  wire logic                      s_axi_awvalid,
	output logic                           s_axi_awready,
	input  wire logic [31:0]               s_axi_wdata,
	input  wire logic [3:0]                s_axi_wstrb,
	input  wire logic                      s_axi_wvalid,
	output logic                           s_axi_wready,
	output logic      [1:0]                s_axi_bresp,
	output logic                           s_axi_bvalid,
	input  wire logic                      s_axi_bready,
	input  wire logic [5:0]                s_axi_araddr,
	input  wire logic                      s_axi_arvalid,
	output logic                           s_axi_arready,
	output logic      [31:0]               s_axi_rdata,
	output logic      [1:0]                s_axi_rresp,
	output logic                           s_axi_rvalid,
	input  wire logic                      s_axi_rready,
	// Non-volatile image
	input  wire logic                      nv_valid,
	input  wire ctep_pkg::ctep_image_t     nv_image,
	output ctep_pkg::ctep_image_t          nv_store,
	output logic                           nv_save,
	// Transceiver pins, one per channel
	input  wire logic [1:0]                termination_state_in,
	input  wire logic [1:0]                transceiver_fault_in,
	output logic      [1:0]                transceiver_standby_out,
	output logic      [1:0]                transceiver_enable_out,
	// Expansion port, three signals per pin
	input  wire logic [7:0]                exp_pin_in,
	output logic      [7:0]                exp_pin_out,
	output logic      [7:0]                exp_pin_oe
);
	// Write channel capture: address and data accepted in either order
	logic        aw_held_ff;
	logic        w_held_ff;
	logic [5:0]  awaddr_ff;
	logic [31:0] wdata_ff;
	logic [3:0]  wstrb_ff;
	logic        bvalid_ff;
	logic [1:0]  bresp_ff;
	logic        rvalid_ff;
	logic [31:0] rdata_ff;
	logic [1:0]  rresp_ff;

	wire aw_take  = s_axi_awvalid && !aw_held_ff && !bvalid_ff;
	wire w_take   = s_axi_wvalid && !w_held_ff && !bvalid_ff;
	wire aw_have  = aw_held_ff || aw_take;
	wire w_have   = w_held_ff || w_take;
	wire wr_fire  = aw_have && w_have && !bvalid_ff;
	wire [5:0]  wr_addr = aw_held_ff ? awaddr_ff : s_axi_awaddr;
	wire [31:0] wr_data = w_held_ff ? wdata_ff : s_axi_wdata;
	wire [3:0]  wr_strb = w_held_ff ? wstrb_ff : s_axi_wstrb;
	wire        wr_b0   = wr_strb[0];
	wire        wr_b1   = wr_strb[1];

	wire sel_can0_w = wr_fire && wr_addr == ctep_pkg::OFS_CAN0_OUT && wr_b0;
	wire sel_can1_w = wr_fire && wr_addr == ctep_pkg::OFS_CAN1_OUT && wr_b0;
	wire sel_dir_w  = wr_fire && wr_addr == ctep_pkg::OFS_EXP_DIR  && wr_b0;
	wire sel_out_w  = wr_fire && wr_addr == ctep_pkg::OFS_EXP_OUT  && wr_b0;
	wire sel_ctl_w  = wr_fire && wr_addr == ctep_pkg::OFS_CTRL;
	wire init0      = sel_ctl_w && wr_b0 && wr_data[ctep_pkg::BIT_INIT0];
	wire init1      = sel_ctl_w && wr_b0 && wr_data[ctep_pkg::BIT_INIT0 + 1];
	wire save_req   = sel_ctl_w && wr_b1 && wr_data[ctep_pkg::BIT_SAVE];
	wire wr_mapped  = wr_addr == ctep_pkg::OFS_CAN0_OUT || wr_addr == ctep_pkg::OFS_CAN1_OUT ||
	                  wr_addr == ctep_pkg::OFS_EXP_DIR  || wr_addr == ctep_pkg::OFS_EXP_OUT ||
	                  wr_addr == ctep_pkg::OFS_CTRL;
	wire nxt_aw_held = !wr_fire && aw_have;
	wire nxt_w_held  = !wr_fire && w_have;
	wire nxt_bvalid  = wr_fire || (bvalid_ff && !s_axi_bready);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			aw_held_ff <= 1'b0;
			w_held_ff  <= 1'b0;
			awaddr_ff  <= 6'h00;
			wdata_ff   <= 32'h00000000;
			wstrb_ff   <= 4'h0;
		end else begin
			aw_held_ff <= nxt_aw_held;
			w_held_ff  <= nxt_w_held;
			if (aw_take) begin
				awaddr_ff <= s_axi_awaddr;
			end
			if (w_take) begin
				wdata_ff <= s_axi_wdata;
				wstrb_ff <= s_axi_wstrb;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			bvalid_ff <= 1'b0;
			bresp_ff  <= ctep_pkg::RESP_OKAY;
		end else if (wr_fire) begin
			bvalid_ff <= 1'b1;
			bresp_ff  <= wr_mapped ? ctep_pkg::RESP_OKAY : ctep_pkg::RESP_SLVERR;
		end else if (s_axi_bready) begin
			bvalid_ff <= 1'b0;
		end
	end

	// Ready ports are registered copies built from the next handshake state, so they match
	// the held and response flops cycle for cycle while still coming straight off a flop
	logic awready_ff;
	logic wready_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			awready_ff <= 1'b1;
			wready_ff  <= 1'b1;
		end else begin
			awready_ff <= !nxt_aw_held && !nxt_bvalid;
			wready_ff  <= !nxt_w_held && !nxt_bvalid;
		end
	end

	assign s_axi_awready = awready_ff;
	assign s_axi_wready  = wready_ff;
	assign s_axi_bvalid  = bvalid_ff;
	assign s_axi_bresp   = bresp_ff;

	// Power-on restore: taken once, on the first cycle the store reports valid
	logic restored_ff;
	wire  restore = nv_valid && !restored_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			restored_ff <= 1'b0;
		end else if (nv_valid) begin
			restored_ff <= 1'b1;
		end
	end

	// Synchronised pins
	logic [1:0] trm_s;
	logic [1:0] err_s;
	logic [7:0] exp_s;

	ctep_sync2 #(.W(2)) u_sync_trm (.clk(clk), .rst(rst), .d(termination_state_in), .q(trm_s));
	ctep_sync2 #(.W(2)) u_sync_err (.clk(clk), .rst(rst), .d(transceiver_fault_in), .q(err_s));
	ctep_sync2 #(.W(8)) u_sync_exp (.clk(clk), .rst(rst), .d(exp_pin_in), .q(exp_s));

	// CAN channels, one independent port each
	logic [7:0] can_last [2];
	logic [1:0] stb_w;
	logic [1:0] en_w;

	ctep_can_chan u_can0 (
		.clk         (clk),
		.rst         (rst),
		.restore     (restore),
		.restore_val (nv_image.can0_out),
		.init        (init0),
		.wr          (sel_can0_w),
		.wdata       (wr_data[7:0]),
		.last_out    (can_last[0]),
		.stb_out     (stb_w[0]),
		.en_out      (en_w[0])
	);

	ctep_can_chan u_can1 (
		.clk         (clk),
		.rst         (rst),
		.restore     (restore),
		.restore_val (nv_image.can1_out),
		.init        (init1),
		.wr          (sel_can1_w),
		.wdata       (wr_data[7:0]),
		.last_out    (can_last[1]),
		.stb_out     (stb_w[1]),
		.en_out      (en_w[1])
	);

	logic [1:0] stb_ff;
	logic [1:0] en_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			stb_ff <= 2'b00;
			en_ff  <= 2'b00;
		end else begin
			stb_ff <= stb_w;
			en_ff  <= en_w;
		end
	end

	assign transceiver_standby_out = stb_ff;
	assign transceiver_enable_out  = en_ff;

	// Expansion port
	logic [7:0] dir_ff;
	logic [7:0] eout_ff;
	logic [7:0] pin_out_ff;
	logic [7:0] pin_oe_ff;
	wire  [7:0] nxt_dir  = sel_dir_w ? wr_data[7:0] :
	                       restore   ? nv_image.exp_dir : dir_ff;
	wire  [7:0] nxt_eout = sel_out_w ? wr_data[7:0] :
	                       restore   ? nv_image.exp_out : eout_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			dir_ff     <= ctep_pkg::RST_EXP_DIR;
			eout_ff    <= ctep_pkg::RST_EXP_OUT;
			pin_out_ff <= 8'h00;
			pin_oe_ff  <= 8'h00;
		end else begin
			dir_ff     <= nxt_dir;
			eout_ff    <= nxt_eout;
			pin_out_ff <= nxt_eout & nxt_dir;
			pin_oe_ff  <= nxt_dir;
		end
	end

	assign exp_pin_out = pin_out_ff;
	assign exp_pin_oe  = pin_oe_ff;

	// Output pins read back what they drive, input pins their sampled level
	wire [7:0] exp_level = (dir_ff & eout_ff) | (~dir_ff & exp_s);

	// Non-volatile save: image follows the live settings, pulse on request
	logic                  nv_save_ff;
	ctep_pkg::ctep_image_t nv_store_ff;

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			nv_save_ff  <= 1'b0;
			nv_store_ff <= '0;
		end else begin
			nv_save_ff  <= save_req;
			nv_store_ff <= '{can1_out: can_last[1], can0_out: can_last[0],
			                 exp_dir: dir_ff, exp_out: eout_ff};
		end
	end

	assign nv_save  = nv_save_ff;
	assign nv_store = nv_store_ff;

	// Read path
	function automatic logic [7:0] can_in_word(input logic [7:0] last, input logic trm, input logic err);
		logic [7:0] v;
		v = 8'h00;
		v[ctep_pkg::BIT_TRM] = trm;
		v[ctep_pkg::BIT_ERR] = err;
		return v | (last & ctep_pkg::CAN_OUT_MASK);
	endfunction : can_in_word

	wire [7:0] can0_rd = can_in_word(can_last[0], trm_s[0], err_s[0]);
	wire [7:0] can1_rd = can_in_word(can_last[1], trm_s[1], err_s[1]);
	wire rd_take = s_axi_arvalid && !rvalid_ff;
	logic [31:0] rd_mux;
	logic        rd_ok;

	always_comb begin
		rd_mux = 32'h00000000;
		rd_ok  = 1'b1;
		unique case (s_axi_araddr)
			ctep_pkg::OFS_CAN0_OUT: rd_mux = {24'h000000, can_last[0]};
			ctep_pkg::OFS_CAN1_OUT: rd_mux = {24'h000000, can_last[1]};
			ctep_pkg::OFS_CAN0_IN:  rd_mux = {24'h000000, can0_rd};
			ctep_pkg::OFS_CAN1_IN:  rd_mux = {24'h000000, can1_rd};
			ctep_pkg::OFS_EXP_DIR:  rd_mux = {24'h000000, dir_ff};
			ctep_pkg::OFS_EXP_OUT:  rd_mux = {24'h000000, eout_ff};
			ctep_pkg::OFS_EXP_IN:   rd_mux = {24'h000000, exp_level};
			ctep_pkg::OFS_CTRL:     rd_mux = {31'h00000000, restored_ff};
			default:                rd_ok  = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			rvalid_ff <= 1'b0;
			rdata_ff  <= 32'h00000000;
			rresp_ff  <= ctep_pkg::RESP_OKAY;
		end else if (rd_take) begin
			rvalid_ff <= 1'b1;
			rdata_ff  <= rd_mux;
			rresp_ff  <= rd_ok ? ctep_pkg::RESP_OKAY : ctep_pkg::RESP_SLVERR;
		end else if (s_axi_rready) begin
			rvalid_ff <= 1'b0;
		end
	end

	logic arready_ff;
	wire  nxt_rvalid = rd_take || (rvalid_ff && !s_axi_rready);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			arready_ff <= 1'b1;
		end else begin
			arready_ff <= !nxt_rvalid;
		end
	end

	assign s_axi_arready = arready_ff;
	assign s_axi_rvalid  = rvalid_ff;
	assign s_axi_rdata   = rdata_ff;
	assign s_axi_rresp   = rresp_ff;
endmodule : ctep_top
`default_nettype wire

// file: sim/ctep_top_props.sv
// Purpose: Port assertions for ctep_top
// Assumes: Bound to every ctep_top instance
// Notes:   Transceiver pins lag their register by one edge
`timescale 1ns/1ps
`default_nettype none
module ctep_top_props (
	input wire logic			clk,
	input wire logic			rst,
	input wire logic [5:0]			s_axi_awaddr,
	input wire logic			s_axi_awvalid,
	input wire logic			s_axi_awready,
	input wire logic [31:0]			s_axi_wdata,
	input wire logic [3:0]			s_axi_wstrb,
	input wire logic			s_axi_wvalid,
	input wire logic			s_axi_wready,
	input wire logic [31:0]			s_axi_rdata,
	input wire logic			s_axi_rvalid,
	input wire ctep_pkg::ctep_image_t	nv_store,
	input wire logic			nv_save,
	input wire logic [1:0]			transceiver_standby_out,
	input wire logic [1:0]			transceiver_enable_out,
	input wire logic [7:0]			exp_pin_out,
	input wire logic [7:0]			exp_pin_oe
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Both channels taken at one edge, which the idle slave always allows
	wire aw = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0];
	wire ctl = aw && s_axi_awaddr == ctep_pkg::OFS_CTRL;
	property p_can(a, i);
		logic [1:0] d;
		(aw && s_axi_awaddr == a, d = s_axi_wdata[7:6])
		|-> ##2 {transceiver_enable_out[i], transceiver_standby_out[i]} == d;
	endproperty
	a_can0_pins: assert property (p_can(ctep_pkg::OFS_CAN0_OUT, 0))
		else $error("CAN0 pins differ from write");
	a_can1_pins: assert property (p_can(ctep_pkg::OFS_CAN1_OUT, 1))
		else $error("CAN1 pins differ from write");
	a_init_run: assert property (ctl && s_axi_wdata[0] |-> ##2 transceiver_enable_out[0] && !transceiver_standby_out[0])
		else $error("Init left CAN0 not running");
	a_dir_oe: assert property (aw && s_axi_awaddr == ctep_pkg::OFS_EXP_DIR |=> exp_pin_oe == $past(s_axi_wdata[7:0]))
		else $error("Pin enables differ from direction");
	a_out_masked: assert property (aw && s_axi_awaddr == ctep_pkg::OFS_EXP_OUT
		|=> (exp_pin_out & exp_pin_oe) == ($past(s_axi_wdata[7:0]) & exp_pin_oe))
		else $error("Driven pins differ from written value");
	a_upper_zero: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
		else $error("Undefined read bits not zero");
	a_image_dir: assert property (nv_store.exp_dir == $past(exp_pin_oe))
		else $error("Saved direction differs from live");
	a_save_pulse: assert property (ctl && s_axi_wstrb[1] && s_axi_wdata[8] |-> ##[1:2] nv_save)
		else $error("Save write gave no store pulse");
	cover property (ctl && s_axi_wdata[8]);
	cover property (aw && s_axi_awaddr == ctep_pkg::OFS_EXP_DIR && s_axi_wdata[7:0] == 8'hFF);
	cover property (s_axi_rvalid);
endmodule : ctep_top_props
`default_nettype wire
bind ctep_top ctep_top_props u_props (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr),
	.s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata),
	.s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
	.s_axi_rdata(s_axi_rdata), .s_axi_rvalid(s_axi_rvalid), .nv_store(nv_store), .nv_save(nv_save),
	.transceiver_standby_out(transceiver_standby_out), .transceiver_enable_out(transceiver_enable_out),
	.exp_pin_out(exp_pin_out), .exp_pin_oe(exp_pin_oe));

// file: sim/ctep_pins_model.sv
// Purpose: Far-side pins and non-volatile store for ctep_top
// Assumes: ext_level is what outside drivers put on input pins
// Notes:   A store not yet ready shows the inverse image, never the last value
`timescale 1ns/1ps
`default_nettype none
module ctep_pins_model (
	input wire logic			clk,
	input wire logic			nv_ok,
	input wire logic [7:0]			ext_level,
	input wire logic [7:0]			exp_pin_out,
	input wire logic [7:0]			exp_pin_oe,
	input wire logic			nv_save,
	input wire ctep_pkg::ctep_image_t	nv_store,
	output logic [7:0]			exp_pin_in,
	output logic				nv_valid,
	output ctep_pkg::ctep_image_t		nv_image
);
	ctep_pkg::ctep_image_t	img_ff = '0;
	// Outside drivers let go of pins that the block drives
	assign exp_pin_in = (exp_pin_out & exp_pin_oe) | (ext_level & ~exp_pin_oe);
	assign nv_valid = nv_ok;
	assign nv_image = nv_ok ? img_ff : ~img_ff;
	always @(posedge clk) begin
		if (nv_save) img_ff <= nv_store;
	end
endmodule : ctep_pins_model
`default_nettype wire

// file: sim/can_transceiver_and_expansion_port_tb.sv
// Purpose: Self-checking bench for ctep_top
// Assumes: Bus answers are compared in arrival order
// Notes:   Pins get three edges to pass the input synchronisers
`timescale 1ns/1ps
`default_nettype none
module can_transceiver_and_expansion_port_tb;
	logic			clk = 1'b0, rst = 1'b1, nv_ok = 1'b0, nv_valid, nv_save;
	logic [5:0]		s_axi_awaddr = 6'h00, s_axi_araddr = 6'h00;
	logic [31:0]		s_axi_wdata = 32'h0, s_axi_rdata;
	logic [3:0]		s_axi_wstrb = 4'hF;
	logic			s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic			s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic			s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	logic [1:0]		s_axi_bresp, s_axi_rresp, termination_state_in = 2'h0, transceiver_fault_in = 2'h0;
	logic [1:0]		transceiver_standby_out, transceiver_enable_out;
	logic [7:0]		exp_pin_in, exp_pin_out, exp_pin_oe, ext_level = 8'h00, v, d, o, e;
	ctep_pkg::ctep_image_t	nv_image, nv_store;
	int			failures = 0, samples_checked = 0;
	logic [31:0]		rq[$];
	logic [1:0]		bq[$];
	logic [1:0]		rrq[$];
	always #2.5 clk = ~clk;
	ctep_top u_dut (.clk(clk), .rst(rst), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
		.s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
		.s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
		.s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
		.s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
		.s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
		.nv_valid(nv_valid), .nv_image(nv_image), .nv_store(nv_store), .nv_save(nv_save),
		.termination_state_in(termination_state_in), .transceiver_fault_in(transceiver_fault_in),
		.transceiver_standby_out(transceiver_standby_out), .transceiver_enable_out(transceiver_enable_out),
		.exp_pin_in(exp_pin_in), .exp_pin_out(exp_pin_out), .exp_pin_oe(exp_pin_oe));
	ctep_pins_model u_pins (.clk(clk), .nv_ok(nv_ok), .ext_level(ext_level), .exp_pin_out(exp_pin_out),
		.exp_pin_oe(exp_pin_oe), .nv_save(nv_save), .nv_store(nv_store), .exp_pin_in(exp_pin_in),
		.nv_valid(nv_valid), .nv_image(nv_image));
	task automatic chk(input string n, input logic [31:0] s, input logic [31:0] x);
		samples_checked++;
		if (s !== x) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", n, x, s);
		end
	endtask : chk
	task automatic wr(input logic [5:0] a, input logic [31:0] dt, input logic [1:0] r = ctep_pkg::RESP_OKAY,
		input logic [3:0] sb = 4'hF);
		bq.push_back(r);
		@(posedge clk);
		s_axi_awaddr <= a;
		s_axi_wdata <= dt;
		s_axi_wstrb <= sb;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
	endtask : wr
	task automatic rd(input logic [5:0] a, input logic [31:0] x, input logic [1:0] r = ctep_pkg::RESP_OKAY);
		rq.push_back(x);
		rrq.push_back(r);
		@(posedge clk);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk);
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
	endtask : rd
	always @(posedge clk) begin
		if (s_axi_rvalid && s_axi_rready) chk("read data", s_axi_rdata, rq.pop_front());
		if (s_axi_rvalid && s_axi_rready) chk("read resp", 32'(s_axi_rresp), 32'(rrq.pop_front()));
		if (s_axi_bvalid && s_axi_bready) chk("write resp", 32'(s_axi_bresp), 32'(bq.pop_front()));
	end
	task automatic end_of_test;
		$display("Comparisons %0d, mismatches %0d", samples_checked, failures);
		if (failures == 0 && samples_checked > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask : end_of_test
	initial begin
		#100000;
		failures++;
		end_of_test();
	end
	initial begin
		void'($urandom(75));
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		rd(ctep_pkg::OFS_EXP_DIR, 32'h0);
		$display("Test reset done");
		for (int ch = 0; ch < 2; ch++) begin
			v = 8'($urandom());
			if (ch == 0) o = v;
			termination_state_in[ch] <= 1'($urandom());
			transceiver_fault_in[ch] <= 1'($urandom());
			wr(6'(4 * ch), {24'hFFFFFF, v});
			repeat (3) @(posedge clk);
			chk("standby pin", 32'(transceiver_standby_out[ch]), 32'(v[6]));
			chk("enable pin", 32'(transceiver_enable_out[ch]), 32'(v[7]));
			rd(6'(4 * ch), {24'h0, v & 8'hC0});
			rd(6'(8 + 4 * ch), {24'h0, v[7:6], transceiver_fault_in[ch], termination_state_in[ch], 4'h0});
		end
		rd(ctep_pkg::OFS_CAN0_OUT, {24'h0, o & 8'hC0});
		for (int ch = 0; ch < 2; ch++) begin
			wr(ctep_pkg::OFS_CTRL, 32'(1 << ch));
			rd(6'(4 * ch), {24'h0, ctep_pkg::CAN_RUN_VALUE});
		end
		$display("Test CAN ports done");
		for (int i = 0; i < 5; i++) begin
			d = (i == 1) ? 8'hFF : 8'($urandom());
			o = 8'($urandom());
			e = 8'($urandom());
			ext_level <= e;
			wr(ctep_pkg::OFS_EXP_DIR, {24'h0, d});
			wr(ctep_pkg::OFS_EXP_OUT, {24'h0, o});
			repeat (3) @(posedge clk);
			chk("pin enables", 32'(exp_pin_oe), 32'(d));
			chk("pin outputs", 32'(exp_pin_out), 32'(o & d));
			rd(ctep_pkg::OFS_EXP_IN, {24'h0, (o & d) | (e & ~d)});
		end
		wr(6'h24, 32'h0000005A, ctep_pkg::RESP_SLVERR);
		rd(6'h24, 32'h0, ctep_pkg::RESP_SLVERR);
		wr(ctep_pkg::OFS_EXP_DIR, {24'h0, ~d}, ctep_pkg::RESP_OKAY, 4'hE);
		rd(ctep_pkg::OFS_EXP_DIR, {24'h0, d});
		$display("Test expansion port done");
		v = 8'($urandom());
		wr(ctep_pkg::OFS_CAN1_OUT, {24'h0, v});
		wr(ctep_pkg::OFS_CTRL, 32'h00000100);
		repeat (3) @(posedge clk);
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		rd(ctep_pkg::OFS_EXP_DIR, 32'h0);
		nv_ok <= 1'b1;
		repeat (3) @(posedge clk);
		rd(ctep_pkg::OFS_EXP_DIR, {24'h0, d});
		rd(ctep_pkg::OFS_CAN1_OUT, {24'h0, v & 8'hC0});
		rd(ctep_pkg::OFS_CTRL, 32'h00000001);
		rd(ctep_pkg::OFS_CAN0_OUT, {24'h0, ctep_pkg::CAN_RUN_VALUE});
		rd(ctep_pkg::OFS_EXP_OUT, {24'h0, o});
		chk("pin enables", 32'(exp_pin_oe), 32'(d));
		chk("standby pin", 32'(transceiver_standby_out[1]), 32'(v[6]));
		chk("enable pin", 32'(transceiver_enable_out[1]), 32'(v[7]));
		$display("Test restore done");
		end_of_test();
	end
endmodule : can_transceiver_and_expansion_port_tb
`default_nettype wire
